/* File: hw/dcpc_counter.sv */
// dcpc_counter: buffered pulse counter for period / frequency capture
// assumes all inputs synchronous to core_clk, the fastest timebase;
// a sample consumer drains the buffer with valid/ready
//
// Overview of operation
// - store pulse count between capture trigger edges
// - default mode samples trigger on count edges
// - default mode writes on first count edge after
// - prevention mode synchronizes both inputs to timebase
// - prevention mode captures without any count edge
// - prevention mode counts each pulse exactly once
// - default mode updates only at count edges
// - prevention mode updates on timebase edges
`timescale 1ns/10ps
`default_nettype none

module dcpc_counter #(
    parameter int unsigned COUNT_W   = dcpc_pkg::DCPC_COUNT_W,
    parameter int unsigned BUF_DEPTH = dcpc_pkg::DCPC_BUF_DEPTH
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    // configuration
    input  wire logic               dup_prevent_en,
    input  wire logic               counter_arm,
    input  wire logic               overflow_clear,
    // external lines
    input  wire logic               counter_count_input,
    input  wire logic               counter_capture_trigger,
    // sample stream
    output logic                    sample_valid,
    input  wire logic               sample_ready,
    output logic      [COUNT_W-1:0] sample_data,
    // status
    output logic                    counter_internal_out,
    output logic      [COUNT_W-1:0] live_count,
    output logic                    mode_prevent_active,
    output logic                    sample_overflow
);

    import dcpc_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    dcpc_mode_e          mode_q;
    logic                armed_q;

    // timebase synchronizers for the prevention mode, one per line
    localparam int unsigned LINES     = 2;
    localparam int unsigned SYNC_LAST = DCPC_SYNC_DEPTH - 1;

    logic [LINES-1:0]    line_pin;
    logic [LINES-1:0]    line_edge;
    logic                src_edge_sync;
    logic                gate_edge_sync;

    // direct sampling for the source-clocked mode
    logic                src_raw_prev_q;
    logic                src_edge_raw;
    logic                gate_at_src_q;
    logic                gate_edge_at_src;

    // shared count path
    logic                count_tick;
    logic                capture_tick;
    logic [COUNT_W-1:0]  count_q;
    logic [COUNT_W-1:0]  count_d;
    logic [COUNT_W-1:0]  capture_value;
    logic                int_out_q;
    logic                overflow_q;

    // buffer fill side
    logic                push_valid_q;
    logic [COUNT_W-1:0]  push_data_q;
    logic                buf_in_ready;

    // ------------------------------------------------------------------
    // helper: rising edge of a sampled level
    // ------------------------------------------------------------------
    function automatic logic rise(input logic now_v, input logic prev_v);
        rise = now_v && !prev_v;
    endfunction : rise

    // ------------------------------------------------------------------
    // configuration bits
    // ------------------------------------------------------------------
    // a mode change lands one edge later; change it only when disarmed
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_q <= DCPC_MODE_SOURCE_CLOCKED;
        end else begin
            mode_q <= dup_prevent_en ? DCPC_MODE_TIMEBASE_SYNC
                                     : DCPC_MODE_SOURCE_CLOCKED;
        end
    end

    // disarming clears the count so the first period starts clean
    always_ff @(posedge core_clk) begin
        if (reset) begin
            armed_q <= DCPC_MODE_RESET;
        end else begin
            armed_q <= counter_arm;
        end
    end

    assign mode_prevent_active = (mode_q == DCPC_MODE_TIMEBASE_SYNC);

    // ------------------------------------------------------------------
    // timebase synchronizers and edge detect
    // ------------------------------------------------------------------
    // a source faster than a quarter of the timebase leaves too few
    // samples per level, so adjacent pulses can merge here
    // bit 0 carries the count input, bit 1 the capture trigger
    assign line_pin = {counter_capture_trigger, counter_count_input};

    for (genvar g = 0; g < LINES; g++) begin : g_sync
        logic [DCPC_SYNC_DEPTH-1:0] stage_q;
        logic                       prev_q;

        // first stage feeds only the second stage
        always_ff @(posedge core_clk) begin
            if (reset) begin
                stage_q <= '0;
            end else begin
                stage_q <= {stage_q[DCPC_SYNC_DEPTH-2:0],
                            line_pin[g]};
            end
        end

        always_ff @(posedge core_clk) begin
            if (reset) begin
                prev_q <= 1'b0;
            end else begin
                prev_q <= stage_q[SYNC_LAST];
            end
        end

        // one pulse per rising edge, however long the level holds
        assign line_edge[g] = rise(stage_q[SYNC_LAST], prev_q);
    end

    assign src_edge_sync  = line_edge[0];
    assign gate_edge_sync = line_edge[1];

    // ------------------------------------------------------------------
    // source-clocked sampling of the trigger
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            src_raw_prev_q <= 1'b0;
        end else begin
            src_raw_prev_q <= counter_count_input;
        end
    end

    // default mode: count edge seen on the raw pin, one flop deep
    assign src_edge_raw = rise(counter_count_input, src_raw_prev_q);

    // trigger level only moves at a count edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            gate_at_src_q <= 1'b0;
        end else if (src_edge_raw) begin
            gate_at_src_q <= counter_capture_trigger;
        end
    end

    // trigger edge seen only by the next count edge
    assign gate_edge_at_src = src_edge_raw &&
                              rise(counter_capture_trigger,
                                   gate_at_src_q);

    // ------------------------------------------------------------------
    // mode select of the count and capture events
    // ------------------------------------------------------------------
    always_comb begin
        count_tick   = 1'b0;
        capture_tick = 1'b0;
        case (mode_q)
            DCPC_MODE_SOURCE_CLOCKED: begin
                count_tick   = armed_q && src_edge_raw;
                capture_tick = armed_q && gate_edge_at_src;
            end
            DCPC_MODE_TIMEBASE_SYNC: begin
                count_tick   = armed_q && src_edge_sync;
                capture_tick = armed_q && gate_edge_sync;
            end
            default: begin
                count_tick   = 1'b0;
                capture_tick = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // pulse counter
    // ------------------------------------------------------------------
    // the value stored is the count before the current edge
    assign capture_value = count_q;

    always_comb begin
        count_d = count_q;
        if (!armed_q) begin
            count_d = COUNT_W'(DCPC_COUNT_ZERO);
        end else if (capture_tick) begin
            // an edge coinciding with capture opens the next period
            count_d = count_tick ? COUNT_W'(DCPC_COUNT_ONE)
                                 : COUNT_W'(DCPC_COUNT_ZERO);
        end else if (count_tick) begin
            count_d = count_q + COUNT_W'(DCPC_COUNT_ONE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q <= COUNT_W'(DCPC_COUNT_ZERO);
        end else begin
            count_q <= count_d;
        end
    end

    assign live_count = count_q;

    // ------------------------------------------------------------------
    // internal output: toggles on each capture
    // ------------------------------------------------------------------
    // one visible change per capture, in the domain of the count
    always_ff @(posedge core_clk) begin
        if (reset) begin
            int_out_q <= 1'b0;
        end else if (capture_tick) begin
            int_out_q <= !int_out_q;
        end
    end

    assign counter_internal_out = int_out_q;

    // ------------------------------------------------------------------
    // capture register feeding the buffer
    // ------------------------------------------------------------------
    // one word waits here while the buffer is full
    always_ff @(posedge core_clk) begin
        if (reset) begin
            push_valid_q <= 1'b0;
        end else if (capture_tick) begin
            push_valid_q <= 1'b1;
        end else if (buf_in_ready) begin
            push_valid_q <= 1'b0;
        end
    end

    // a pending word is held until the buffer takes it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            push_data_q <= COUNT_W'(DCPC_COUNT_ZERO);
        end else if (capture_tick && (!push_valid_q || buf_in_ready)) begin
            push_data_q <= capture_value;
        end
    end

    // ------------------------------------------------------------------
    // overflow: capture lost while a word still waits
    // ------------------------------------------------------------------
    // a set in the same cycle as a clear wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            overflow_q <= 1'b0;
        end else if (capture_tick && push_valid_q && !buf_in_ready) begin
            overflow_q <= 1'b1;
        end else if (overflow_clear) begin
            overflow_q <= 1'b0;
        end
    end

    assign sample_overflow = overflow_q;

    // ------------------------------------------------------------------
    // sample buffer
    // ------------------------------------------------------------------
    dcpc_sample_buf #(
        .WIDTH (COUNT_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (push_valid_q),
        .in_ready  (buf_in_ready),
        .in_data   (push_data_q),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample_data)
    );

endmodule : dcpc_counter

`default_nettype wire

/* File: hw/dcpc_pkg.sv */
// dcpc_pkg: shared constants and types for the buffered pulse counter
// assumes one core clock acting as the fastest onboard timebase
package dcpc_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int unsigned DCPC_COUNT_W    = 32;
    localparam int unsigned DCPC_BUF_DEPTH  = 2;
    localparam int unsigned DCPC_SYNC_DEPTH = 2;

    // ------------------------------------------------------------------
    // timing: core timebase and source ratio limit
    // ------------------------------------------------------------------
    localparam int unsigned DCPC_CLK_PERIOD_NS   = 100;
    localparam int unsigned DCPC_SRC_RATIO_LIMIT = 4;
    // shortest legal source period in the prevention mode, in ns
    localparam int unsigned DCPC_MIN_SRC_PERIOD_NS =
        DCPC_CLK_PERIOD_NS * DCPC_SRC_RATIO_LIMIT;
    // same figure as a count of core cycles
    localparam int unsigned DCPC_MIN_SRC_CYCLES =
        (DCPC_MIN_SRC_PERIOD_NS + DCPC_CLK_PERIOD_NS - 1)
        / DCPC_CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // reset values and modes
    // ------------------------------------------------------------------
    localparam logic DCPC_MODE_RESET = 1'b0;

    typedef enum logic {
        DCPC_MODE_SOURCE_CLOCKED,
        DCPC_MODE_TIMEBASE_SYNC
    } dcpc_mode_e;

    typedef logic [DCPC_COUNT_W-1:0] dcpc_count_t;

    localparam dcpc_count_t DCPC_COUNT_ZERO = '0;
    localparam dcpc_count_t DCPC_COUNT_ONE  = dcpc_count_t'(1);

endpackage : dcpc_pkg

/* File: hw/dcpc_sample_buf.sv */
// dcpc_sample_buf: small valid/ready buffer holding captured counts
// assumes one clock, synchronous active high reset, power-of-two depth
`timescale 1ns/10ps
`default_nettype none

module dcpc_sample_buf #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    import dcpc_pkg::*;

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    // ------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] fill_q;
    logic             push;
    logic             pop;

    assign in_ready  = (fill_q != FULL_CNT);
    assign out_valid = (fill_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    // ------------------------------------------------------------------
    // write side
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0
                                                       : wr_ptr_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // read side and fill level
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0
                                                       : rd_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fill_q <= '0;
        end else if (push && !pop) begin
            fill_q <= fill_q + 1'b1;
        end else if (pop && !push) begin
            fill_q <= fill_q - 1'b1;
        end
    end

endmodule : dcpc_sample_buf

`default_nettype wire

/* File: testbench/dcpc_counter_properties.sv */
// dcpc_counter_properties: port-level checks on dcpc_counter
// assumes bound to every dcpc_counter instance, one clock domain
`timescale 1ns/10ps
`default_nettype none

module dcpc_counter_properties #(
    parameter int unsigned COUNT_W   = 32,
    parameter int unsigned BUF_DEPTH = 2
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    // configuration
    input  wire logic               dup_prevent_en,
    input  wire logic               counter_arm,
    input  wire logic               overflow_clear,
    // external lines
    input  wire logic               counter_count_input,
    input  wire logic               counter_capture_trigger,
    // sample stream
    input  wire logic               sample_valid,
    input  wire logic               sample_ready,
    input  wire logic [COUNT_W-1:0] sample_data,
    // status
    input  wire logic               counter_internal_out,
    input  wire logic [COUNT_W-1:0] live_count,
    input  wire logic               mode_prevent_active,
    input  wire logic               sample_overflow
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // capture steps in the timebase mode, then the port checks of both modes
    // ------------------------------------------------------------------
    sequence trig_rise_armed;
        mode_prevent_active && !sample_valid && counter_arm &&
        $past(counter_arm) && $rose(counter_capture_trigger)
        ##1 counter_arm [*2];
    endsequence
    sequence out_toggled;
        counter_internal_out != $past(counter_internal_out);
    endsequence

    reset_vals_a: assert property ($fell(reset) |-> !sample_valid &&
        live_count == '0 && !sample_overflow && !mode_prevent_active &&
        !counter_internal_out) else $error("outputs not cleared by reset");
    mode_follow_a: assert property (!$past(reset) |->
        mode_prevent_active == $past(dup_prevent_en))
        else $error("mode flag does not follow enable");
    hold_valid_a: assert property (sample_valid && !sample_ready |=>
        sample_valid && $stable(sample_data))
        else $error("sample dropped while stalled");
    disarm_zero_a: assert property (!counter_arm [*3] |->
        live_count == '0) else $error("count not cleared when disarmed");
    dflt_quiet_a: assert property ((!mode_prevent_active &&
        counter_arm && !counter_count_input) [*4] |-> $stable(live_count))
        else $error("count moved without a count edge");
    prev_once_a: assert property ((mode_prevent_active &&
        counter_arm && counter_count_input && !counter_capture_trigger) [*8]
        |-> $stable(live_count)) else $error("long pulse counted twice");
    prev_capture_a: assert property (trig_rise_armed |->
        ##[0:3] out_toggled) else $error("trigger edge not captured");
    dflt_no_cap_a: assert property ((!mode_prevent_active &&
        !counter_count_input) [*5] |-> $stable(counter_internal_out))
        else $error("capture without a count edge");
    ovf_sticky_a: assert property (sample_overflow && !overflow_clear |=>
        sample_overflow) else $error("overflow flag lost");

endmodule : dcpc_counter_properties

bind dcpc_counter dcpc_counter_properties #(
    .COUNT_W  (COUNT_W),
    .BUF_DEPTH(BUF_DEPTH)
) dcpc_counter_properties_i (
    .core_clk               (core_clk),
    .reset                  (reset),
    .dup_prevent_en         (dup_prevent_en),
    .counter_arm            (counter_arm),
    .overflow_clear         (overflow_clear),
    .counter_count_input    (counter_count_input),
    .counter_capture_trigger(counter_capture_trigger),
    .sample_valid           (sample_valid),
    .sample_ready           (sample_ready),
    .sample_data            (sample_data),
    .counter_internal_out   (counter_internal_out),
    .live_count             (live_count),
    .mode_prevent_active    (mode_prevent_active),
    .sample_overflow        (sample_overflow)
);
`default_nettype wire

/* File: testbench/dcpc_pulse_src.sv */
// dcpc_pulse_src: external count pulse and capture trigger lines
// assumes callers enter its tasks at a falling edge of core_clk
`timescale 1ns/10ps
`default_nettype none

module dcpc_pulse_src (
    // clock
    input  wire logic core_clk,
    // external lines, pulled low when idle
    output var  logic count_line,
    output var  logic trig_line
);
    initial begin
        count_line = 1'b0;
        trig_line  = 1'b0;
    end

    // hi and lo of 2 or more keep the period at 4 or more timebase cycles
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n) begin
            count_line = 1'b1;
            repeat (hi) @(negedge core_clk);
            count_line = 1'b0;
            repeat (lo) @(negedge core_clk);
        end
    endtask : pulses

    task automatic trig(input logic v, input int hold);
        trig_line = v;
        repeat (hold) @(negedge core_clk);
    endtask : trig
endmodule : dcpc_pulse_src
`default_nettype wire

/* File: testbench/test_dcpc_counter.sv */
// test_dcpc_counter: self-checking bench for dcpc_counter
// assumes dcpc_pulse_src drives the external lines at falling edges
`timescale 1ns/10ps
`default_nettype none

module test_dcpc_counter;
    import dcpc_pkg::*;
    logic        core_clk;
    logic        reset;
    logic        dup_prevent_en;
    logic        counter_arm;
    logic        overflow_clear;
    logic        counter_count_input;
    logic        counter_capture_trigger;
    logic        sample_valid;
    logic        sample_ready;
    dcpc_count_t sample_data;
    logic        counter_internal_out;
    dcpc_count_t live_count;
    logic        mode_prevent_active;
    logic        sample_overflow;
    logic        iout0;
    int          err_total;
    int          n_checks;

    dcpc_counter dcpc_counter_i (
        .core_clk               (core_clk),
        .reset                  (reset),
        .dup_prevent_en         (dup_prevent_en),
        .counter_arm            (counter_arm),
        .overflow_clear         (overflow_clear),
        .counter_count_input    (counter_count_input),
        .counter_capture_trigger(counter_capture_trigger),
        .sample_valid           (sample_valid),
        .sample_ready           (sample_ready),
        .sample_data            (sample_data),
        .counter_internal_out   (counter_internal_out),
        .live_count             (live_count),
        .mode_prevent_active    (mode_prevent_active),
        .sample_overflow        (sample_overflow)
    );
    dcpc_pulse_src dcpc_pulse_src_i (
        .core_clk  (core_clk),
        .count_line(counter_count_input),
        .trig_line (counter_capture_trigger)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic check(input dcpc_count_t seen, input dcpc_count_t exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle

    // waits for a word, compares it, then takes it in one cycle
    task automatic pop(input dcpc_count_t exp);
        int n;
        n = 0;
        while (sample_valid !== 1'b1 && n < 40) begin
            idle(1);
            n++;
        end
        check(sample_valid, 1'b1);
        check(sample_data, exp);
        sample_ready = 1'b1;
        idle(1);
        sample_ready = 1'b0;
        idle(1);
    endtask : pop

    task automatic t_default();
        counter_arm = 1'b1;
        idle(2);
        dcpc_pulse_src_i.pulses(7, 1, 1);
        dcpc_pulse_src_i.trig(1'b1, 6);
        check(sample_valid, 1'b0);
        iout0 = counter_internal_out;
        dcpc_pulse_src_i.pulses(1, 1, 3);
        check(counter_internal_out, !iout0);
        pop(32'h0000_0007);
        dcpc_pulse_src_i.trig(1'b0, 1);
        dcpc_pulse_src_i.pulses(1, 1, 1);
        dcpc_pulse_src_i.trig(1'b1, 4);
        check(sample_valid, 1'b0);
        dcpc_pulse_src_i.pulses(1, 1, 3);
        pop(32'h0000_0002);
        check(live_count, 32'h0000_0001);
        dcpc_pulse_src_i.trig(1'b0, 1);
        $display("test default mode done");
    endtask : t_default

    task automatic t_prevent();
        counter_arm    = 1'b0;
        dup_prevent_en = 1'b1; // timebase-synchronized mode
        idle(3);
        check(mode_prevent_active, 1'b1);
        check(live_count, 32'h0000_0000);
        counter_arm = 1'b1;
        idle(2);
        dcpc_pulse_src_i.pulses(3, 12, 4);
        iout0 = counter_internal_out;
        dcpc_pulse_src_i.trig(1'b1, 6);
        check(counter_internal_out, !iout0);
        pop(32'h0000_0003);
        dcpc_pulse_src_i.trig(1'b0, 4);
        dcpc_pulse_src_i.trig(1'b1, 4);
        pop(32'h0000_0000);
        dcpc_pulse_src_i.trig(1'b0, 2);
        $display("test timebase mode done");
    endtask : t_prevent

    // consumer stalls: two buffer words, one held capture, one dropped
    task automatic t_overflow();
        for (int k = 1; k <= 4; k++) begin
            dcpc_pulse_src_i.pulses(k, 2, 2);
            dcpc_pulse_src_i.trig(1'b1, 6);
            check(sample_overflow, k == 4);
            dcpc_pulse_src_i.trig(1'b0, 2);
        end
        pop(32'h0000_0001);
        pop(32'h0000_0002);
        pop(32'h0000_0003);
        idle(4);
        check(sample_valid, 1'b0);
        overflow_clear = 1'b1;
        idle(1);
        overflow_clear = 1'b0;
        idle(1);
        check(sample_overflow, 1'b0);
        $display("test overflow done");
    endtask : t_overflow

    initial begin
        reset          = 1'b1;
        dup_prevent_en = 1'b0;
        counter_arm    = 1'b0;
        overflow_clear = 1'b0;
        sample_ready   = 1'b0;
        err_total      = 0;
        n_checks       = 0;
        idle(8);
        reset = 1'b0;
        idle(2);
        check({mode_prevent_active, sample_valid}, 2'h0);
        check({sample_overflow, counter_internal_out}, 2'h0);
        check(live_count, 32'h0000_0000);
        $display("test reset done");
        t_default();
        t_prevent();
        t_overflow();
        test_done();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        test_done();
    end
endmodule : test_dcpc_counter
`default_nettype wire
